//--- design/fses_status_engine.sv
/*
 * Write engine status word and erase suspend/resume sequencer.
 * Assumes bus writes arrive as one-cycle strobes synchronous to sys_clk,
 * and that the array core reports completion, verify failures and
 * the supply level on plain inputs.
 */
`timescale 1ns/1ps
// Functional notes
// - Ready means no plane program or erase
// - Busy, plane bit zero: addressed plane busy
// - Busy, plane bit one: other plane busy
// - Suspend bits show suspended erase/program
// - Program bit set on program failure
// - Low supply sets bit, aborts operation
// - Program suspend bit one while suspended
// - Locked sector op aborts, sets lock bit
// - Sequence error sets bits 1,3,4,5
// - Suspend ignored during full-chip erase
// - Suspended within 15 microseconds
// - Suspended plane allows reads, other programs
// - Suspend accepted at any address
// - No new erase while erase suspended
// - Only listed commands accepted while suspended
// - Status read: upper byte zero
// - Error bits held until clear status
module fses_status_engine
    import fses_pkg::*;
(
    input  wire logic                 sys_clk,       // 125 MHz clock
    input  wire logic                 rst_n,         // Async reset, active low
    input  wire logic                 bus_wr,        // One-cycle write strobe
    input  wire logic [15:0]          bus_wdata,     // Write data
    input  wire logic [fses_pkg::PLANE_W-1:0] bus_plane, // Addressed plane
    input  wire logic [fses_pkg::SECT_W-1:0]  bus_sector,// Addressed sector
    input  wire logic                 bus_rd,        // One-cycle status read strobe
    input  wire logic                 sector_locked, // Addressed sector protected
    input  wire logic                 supply_ok,     // Program supply acceptable
    input  wire logic                 op_done,       // Core finished operation
    input  wire logic                 op_fail,       // Core verify failed
    output logic [15:0]               bus_rdata,     // Latched status read data
    output logic                      status_mode,   // Reads return status
    output logic                      start_op,      // Pulse to core: begin op
    output logic [1:0]                start_kind,    // Operation kind
    output logic                      core_hold,     // Core must freeze
    output logic [7:0]                device_status_word // Live status word
);
    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    fses_state_t st_q, st_d;                    // Engine state
    fses_op_t    op_q;                          // Running operation
    logic [PLANE_W-1:0] plane_q;                // Plane of running op
    logic [PLANE_W-1:0] susp_plane_q;           // Plane of suspended erase
    logic [SECT_W-1:0]  susp_sect_q;            // Sector of suspended erase
    logic        esusp_q;                       // Erase held underneath program
    logic [7:0]  setup_q;                       // Pending first-cycle command
    logic        setup_v_q;                     // First cycle seen
    logic        eerr_q, perr_q, supp_q, lock_q; // Sticky error bits
    logic [10:0] drain_q;                       // Suspend latency counter
    logic        status_mode_q;                 // Read status selected
    logic [15:0] rdata_q;                       // Read data register
    logic        start_q;                       // Start pulse
    logic [1:0]  kind_q;                        // Start kind

    wire [7:0] cmd = bus_wdata[7:0];            // Command byte
    wire allowed;                               // Filter result

    // ------------------------------------------------------------
    // Command filter during suspend
    // ------------------------------------------------------------
    fses_cmd_filter u_filter (
        .cmd     (cmd),
        .esusp   (st_q == ST_ESUSP || esusp_q),
        .psusp   (st_q == ST_PSUSP),
        .allowed (allowed)
    );

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Second cycles carry data, so only first cycles are filtered
    wire wr_ok      = bus_wr && (allowed || setup_v_q);
    wire is_first   = wr_ok && !setup_v_q;
    wire is_second  = wr_ok && setup_v_q;
    wire engine_idle = (st_q == ST_IDLE) || (st_q == ST_ESUSP);
    wire erase_held = (st_q == ST_ESUSP) || esusp_q;
    // Suspend needs no address; full-chip erase ignores it
    wire do_susp    = is_first && cmd == CMD_SUSPEND && st_q == ST_BUSY
                   && op_q != OP_CERA;
    wire do_resume  = is_first && cmd == CMD_RESUME;
    wire e_resume   = do_resume && st_q == ST_ESUSP
                   && bus_plane == susp_plane_q;
    wire p_resume   = do_resume && st_q == ST_PSUSP;
    wire do_clear   = is_first && cmd == CMD_CLRSTAT;
    wire second_op  = is_second && (setup_q == CMD_PROG || setup_q == CMD_ERASE
                   || setup_q == CMD_PERASE || setup_q == CMD_CERASE);
    wire is_erase2  = setup_q != CMD_PROG;
    // Second cycle must confirm erases with the resume code
    wire bad_seq    = second_op && is_erase2 && cmd != CMD_RESUME;
    // Suspended erase blocks new erases; its own sector stays off limits
    wire blocked    = second_op && ((is_erase2 && erase_held)
                   || (erase_held && bus_sector == susp_sect_q));
    // Low supply and locks abort; after a supply error only a resume starts an op until clear
    wire go_op      = second_op && !bad_seq && !blocked && engine_idle && !supp_q;
    wire lock_abort = go_op && sector_locked;
    wire supp_abort = go_op && !sector_locked && !supply_ok;
    wire launch     = go_op && !sector_locked && supply_ok;
    wire busy_fail  = st_q == ST_BUSY && !supply_ok;
    wire finish     = st_q == ST_BUSY && op_done;
    wire drained    = st_q == ST_DRAIN && drain_q == 11'd0;

    fses_op_t new_op;
    assign new_op = (setup_q == CMD_PROG)   ? OP_PROG :
                    (setup_q == CMD_ERASE)  ? OP_SERA :
                    (setup_q == CMD_PERASE) ? OP_PERA : OP_CERA;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE:  if (launch) st_d = ST_BUSY;
            ST_BUSY: begin
                if (busy_fail || finish) begin
                    st_d = esusp_q ? ST_ESUSP : ST_IDLE;           // Back to held erase
                end else if (do_susp) begin
                    st_d = (op_q == OP_PROG) ? ST_PSUSP : ST_DRAIN;
                end
            end
            ST_DRAIN: if (drained) st_d = ST_ESUSP;
            ST_ESUSP: begin
                if (e_resume) st_d = ST_BUSY;
                else if (launch) st_d = ST_BUSY;                   // Program in other sector
            end
            ST_PSUSP: if (p_resume) st_d = ST_BUSY;
            default:  st_d = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State, operation and suspend bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q         <= ST_IDLE;
            op_q         <= OP_PROG;
            plane_q      <= '0;
            susp_plane_q <= '0;
            esusp_q      <= 1'b0;
            drain_q      <= '0;
        end else begin
            st_q <= st_d;
            if (launch) begin
                op_q    <= new_op;
                plane_q <= bus_plane;
            end
            if (do_susp && op_q != OP_PROG) begin
                susp_plane_q <= plane_q;
                drain_q      <= SUSP_LAT;
            end else if (st_q == ST_DRAIN && drain_q != 11'd0) begin
                drain_q <= drain_q - 11'd1;
            end
            if (launch && st_q == ST_ESUSP) begin
                esusp_q <= 1'b1;                                   // Erase parked below
            end else if (st_q == ST_BUSY && (busy_fail || finish)) begin
                esusp_q <= 1'b0;
            end
            if (e_resume) begin
                op_q    <= OP_SERA;
                plane_q <= susp_plane_q;
            end
        end
    end

    // Sector of the last sector erase launched
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            susp_sect_q <= '0;
        end else if (launch && new_op == OP_SERA) begin
            susp_sect_q <= bus_sector;
        end
    end

    // ------------------------------------------------------------
    // Two-cycle command tracking and read mode
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_q       <= 8'h00;
            setup_v_q     <= 1'b0;
            status_mode_q <= 1'b0;
        end else if (wr_ok) begin
            setup_v_q <= !setup_v_q && (cmd == CMD_PROG || cmd == CMD_ERASE
                      || cmd == CMD_PERASE || cmd == CMD_CERASE || cmd == CMD_LOCK);
            setup_q   <= cmd;
            if (is_first) begin
                status_mode_q <= (cmd == CMD_RDSTAT) || (cmd == CMD_SUSPEND);
            end
            if (second_op) begin
                status_mode_q <= 1'b1;                             // Status follows op
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky error bits, set wins over clear
    // ------------------------------------------------------------
    wire fail_now = finish && op_fail;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eerr_q <= 1'b0;
            perr_q <= 1'b0;
            supp_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            // Only clear status drops them
            // Set terms
            eerr_q <= (fail_now && op_q != OP_PROG) || bad_seq || (eerr_q && !do_clear);
            perr_q <= (fail_now && op_q == OP_PROG) || bad_seq || (perr_q && !do_clear);
            supp_q <= supp_abort || busy_fail || bad_seq || (supp_q && !do_clear);
            lock_q <= lock_abort || bad_seq || (lock_q && !do_clear);
        end
    end

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    wire running = (st_q == ST_BUSY) || (st_q == ST_DRAIN);
    always_comb begin
        device_status_word            = 8'h00;
        device_status_word[SR_READY]  = !running;
        device_status_word[SR_ESUSP]  = erase_held;
        device_status_word[SR_EERR]   = eerr_q;
        device_status_word[SR_PERR]   = perr_q;
        device_status_word[SR_SUPPLY] = supp_q;
        device_status_word[SR_PSUSP]  = st_q == ST_PSUSP;
        device_status_word[SR_LOCK]   = lock_q;
        device_status_word[SR_PLANE]  = running && bus_plane != plane_q;
    end

    // ------------------------------------------------------------
    // Read data latch and core start pulse
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
            start_q <= 1'b0;
            kind_q  <= 2'd0;
        end else begin
            if (bus_rd) begin
                rdata_q <= {UPPER_ZERO, device_status_word};
            end
            start_q <= launch || e_resume || p_resume;
            if (launch) begin
                kind_q <= new_op;
            end else if (e_resume) begin
                kind_q <= OP_SERA;
            end
        end
    end

    assign bus_rdata   = rdata_q;
    assign status_mode = status_mode_q;
    assign start_op    = start_q;
    assign start_kind  = kind_q;
    // A program beside a held erase must keep running
    assign core_hold   = (st_q == ST_ESUSP) || (st_q == ST_PSUSP)
                      || (st_q == ST_DRAIN);
endmodule

//--- pkg/fses_pkg.sv
/*
 * Constants and types for the flash status and erase suspend block.
 * Assumes a single 125 MHz system clock and synchronous bus strobes.
 */
package fses_pkg;
    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int SR_READY    = 7;  // Engine ready
    localparam int SR_ESUSP    = 6;  // Erase suspended
    localparam int SR_EERR     = 5;  // Erase error
    localparam int SR_PERR     = 4;  // Program error
    localparam int SR_SUPPLY   = 3;  // Supply low
    localparam int SR_PSUSP    = 2;  // Program suspended
    localparam int SR_LOCK     = 1;  // Locked sector abort
    localparam int SR_PLANE    = 0;  // Other plane busy

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int PLANE_W = 5;                          // Thirty-two planes
    localparam int SECT_W  = 9;                          // Sector index width
    localparam logic [7:0]  STATUS_RST = 8'h80;          // Ready, no errors
    localparam logic [7:0]  UPPER_ZERO = 8'h00;          // Upper data byte on status read

    // ------------------------------------------------------------
    // Command codes on the low data byte
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ      = 8'hff;
    localparam logic [7:0] CMD_RDSTAT    = 8'h70;
    localparam logic [7:0] CMD_CLRSTAT   = 8'h50;
    localparam logic [7:0] CMD_IDENT     = 8'h90;
    localparam logic [7:0] CMD_PROG      = 8'h40;
    localparam logic [7:0] CMD_ERASE     = 8'h20;
    localparam logic [7:0] CMD_PERASE    = 8'h80;
    localparam logic [7:0] CMD_CERASE    = 8'h30;
    localparam logic [7:0] CMD_SUSPEND   = 8'hb0;
    localparam logic [7:0] CMD_RESUME    = 8'hd0;
    localparam logic [7:0] CMD_LOCK      = 8'h60;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 125;
    localparam int SUSP_MAX_US     = 15;                         // Longest suspend latency
    localparam int SUSP_MAX_CYC    = SUSP_MAX_US * CLK_MHZ;      // Exact product, 1875 cycles
    localparam int SUSP_LAT_CYC    = 64;                         // Actual drain time
    localparam logic [10:0] SUSP_LAT = 11'(SUSP_LAT_CYC);

    // ------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,  // Ready
        ST_BUSY    = 5'b00010,  // Program or erase running
        ST_DRAIN   = 5'b00100,  // Erase halting after suspend
        ST_ESUSP   = 5'b01000,  // Erase suspended
        ST_PSUSP   = 5'b10000   // Program suspended
    } fses_state_t;

    typedef enum logic [1:0] {
        OP_PROG  = 2'd0,
        OP_SERA  = 2'd1,
        OP_PERA  = 2'd2,
        OP_CERA  = 2'd3
    } fses_op_t;
endpackage

//--- design/fses_cmd_filter.sv
/*
 * Command acceptance filter while an erase or a program is suspended.
 * Assumes the command byte is valid whenever a write strobe is seen.
 */
`timescale 1ns/1ps
module fses_cmd_filter
    import fses_pkg::*;
(
    input  wire logic [7:0] cmd,       // Command byte
    input  wire logic       esusp,     // Erase suspended
    input  wire logic       psusp,     // Program suspended
    output logic            allowed    // Command may proceed
);
    // ------------------------------------------------------------
    // Permitted set per suspend mode
    // ------------------------------------------------------------
    wire in_esusp_set = (cmd == CMD_READ) || (cmd == CMD_RDSTAT) || (cmd == CMD_IDENT)
                     || (cmd == CMD_CLRSTAT) || (cmd == CMD_PROG) || (cmd == CMD_SUSPEND)
                     || (cmd == CMD_RESUME) || (cmd == CMD_LOCK);
    wire in_psusp_set = (cmd == CMD_READ) || (cmd == CMD_RDSTAT) || (cmd == CMD_IDENT)
                     || (cmd == CMD_RESUME);

    assign allowed = psusp ? in_psusp_set : (esusp ? in_esusp_set : 1'b1);
endmodule

//--- dv/fses_status_engine_sva.sv
/* Port assertions for the status engine.
   Assumes it is bound to every fses_status_engine instance. */
`timescale 1ns/1ps
module fses_status_engine_sva (
    input wire logic                          sys_clk,
    input wire logic                          rst_n,
    input wire logic                          bus_wr,
    input wire logic [15:0]                   bus_wdata,
    input wire logic [fses_pkg::PLANE_W-1:0]  bus_plane,
    input wire logic [fses_pkg::SECT_W-1:0]   bus_sector,
    input wire logic                          bus_rd,
    input wire logic                          sector_locked,
    input wire logic                          supply_ok,
    input wire logic                          op_done,
    input wire logic                          op_fail,
    input wire logic [15:0]                   bus_rdata,
    input wire logic                          status_mode,
    input wire logic                          start_op,
    input wire logic [1:0]                    start_kind,
    input wire logic                          core_hold,
    input wire logic [7:0]                    device_status_word
);
    import fses_pkg::*;
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [PLANE_W-1:0] plane_d_q;    // Plane of the last bus cycle
    logic [PLANE_W-1:0] run_plane_q;  // Plane of the running op
    wire  [PLANE_W-1:0] run_plane = start_op ? plane_d_q : run_plane_q;
    wire                clr_cmd   = bus_wr && (bus_wdata[7:0] == CMD_CLRSTAT);
    wire                res_cmd   = bus_wr && (bus_wdata[7:0] == CMD_RESUME);
    // Track which plane the engine runs on
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            plane_d_q   <= '0;
            run_plane_q <= '0;
        end else begin
            plane_d_q   <= bus_plane;
            run_plane_q <= run_plane;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_busy_on_start; start_op |-> !device_status_word[7]; endproperty
    a_busy_on_start: assert property (p_busy_on_start)
        else $error("ready high while an op starts");
    property p_ready_quiet;
        device_status_word[7] && !device_status_word[6] && !device_status_word[2]
            |-> !core_hold && !start_op;
    endproperty
    a_ready_quiet: assert property (p_ready_quiet)
        else $error("ready shown with engine active");
    property p_plane_bit;
        !device_status_word[7] && !core_hold && start_kind != OP_CERA
            |-> device_status_word[0] == (bus_plane != run_plane);
    endproperty
    a_plane_bit: assert property (p_plane_bit)
        else $error("plane bit wrong for addressed plane");
    property p_rd_upper; bus_rd |=> bus_rdata[15:8] == UPPER_ZERO; endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("upper read byte not zero");
    property p_rd_low; bus_rd |=> bus_rdata[7:0] == $past(device_status_word); endproperty
    a_rd_low: assert property (p_rd_low)
        else $error("read byte differs from status");
    property p_err_hold;
        (|(device_status_word & 8'h3a)) && !clr_cmd |=>
            ((device_status_word & 8'h3a) & $past(device_status_word)) ==
            ($past(device_status_word) & 8'h3a);
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error bit lost without clear");
    property p_susp_hold; device_status_word[6] && !res_cmd |=> device_status_word[6]; endproperty
    a_susp_hold: assert property (p_susp_hold)
        else $error("erase suspend bit lost without resume");
    property p_susp_ready; $rose(device_status_word[6]) |-> device_status_word[7]; endproperty
    a_susp_ready: assert property (p_susp_ready)
        else $error("suspend shown without ready");
    property p_susp_lat; $rose(core_hold) |-> ##[1:1000] device_status_word[7]; endproperty
    a_susp_lat: assert property (p_susp_lat)
        else $error("suspend took too long");
    property p_chip_nosusp; start_kind == OP_CERA && !device_status_word[7] |-> !core_hold; endproperty
    a_chip_nosusp: assert property (p_chip_nosusp)
        else $error("chip erase was suspended");
endmodule
bind fses_status_engine fses_status_engine_sva u_sva (.sys_clk, .rst_n, .bus_wr,
    .bus_wdata, .bus_plane, .bus_sector, .bus_rd, .sector_locked, .supply_ok, .op_done,
    .op_fail, .bus_rdata, .status_mode, .start_op, .start_kind, .core_hold,
    .device_status_word);

//--- dv/fses_core_model.sv
/* Behavioural array core that runs the engine's operations.
   Assumes start_op pulses one cycle and core_hold freezes the count. */
`timescale 1ns/1ps
module fses_core_model #(
    parameter int OP_CYC = 100  // Cycles per operation
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic start_op,
    input  wire logic core_hold,
    input  wire logic fail_next,  // Bench asks for a verify failure
    output logic      op_done,
    output logic      op_fail
);
    logic [11:0] cnt_q;  // Cycles left
    // Count down, frozen while held; fail flag meaningless outside done
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            op_done <= 1'b0;
            op_fail <= 1'b0;
        end else begin
            op_done <= 1'b0;
            op_fail <= ~op_fail;
            if (start_op) begin
                cnt_q <= 12'(OP_CYC);
            end else if (cnt_q != 12'h000 && !core_hold) begin
                cnt_q <= cnt_q - 12'h001;
                if (cnt_q == 12'h001) begin
                    op_done <= 1'b1;
                    op_fail <= fail_next;
                end
            end
        end
    end
endmodule

//--- dv/fses_status_engine_bench.sv
/* Command sequence bench for the status engine.
   Assumes the core model answers every started operation. */
`timescale 1ns/1ps
module fses_status_engine_bench;
    import fses_pkg::*;
    logic               sys_clk, rst_n, bus_wr, bus_rd, sector_locked, supply_ok, fail_next;
    logic [15:0]        bus_wdata, bus_rdata;
    logic [PLANE_W-1:0] bus_plane;
    logic [SECT_W-1:0]  bus_sector;
    logic               op_done, op_fail, status_mode, start_op, core_hold;
    logic [1:0]         start_kind;
    logic [7:0]         dsw;
    int                 fail_count, checks_done, starts, n, s0;
    fses_status_engine u_dut (.sys_clk, .rst_n, .bus_wr, .bus_wdata, .bus_plane, .bus_sector,
        .bus_rd, .sector_locked, .supply_ok, .op_done, .op_fail, .bus_rdata, .status_mode,
        .start_op, .start_kind, .core_hold, .device_status_word(dsw));
    fses_core_model u_core (.sys_clk, .rst_n, .start_op, .core_hold, .fail_next, .op_done,
        .op_fail);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (start_op === 1'b1) starts++;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One idle edge, then one bus write
    task automatic wr(input logic [7:0] cmd, input logic [PLANE_W-1:0] pl);
        @(posedge sys_clk);
        bus_wr    <= 1'b1;
        bus_wdata <= {8'h00, cmd};
        bus_plane <= pl;
        @(posedge sys_clk);
        bus_wr    <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] exp, input logic [7:0] msk);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 chk(what, {8'h00, exp & msk}, {bus_rdata[15:8], bus_rdata[7:0] & msk});
    endtask
    task automatic wait_ready();
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (dsw[7] !== 1'b1 && n < 3000);
    endtask
    task automatic end_sim();
        $display("Counts: checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog against a hung engine
    initial begin
        #(8 * 30000);
        fail_count++;
        $display("Error watchdog expected finish seen hang");
        end_sim();
    end
    initial begin
        {rst_n, bus_wr, bus_rd, fail_next, bus_wdata, bus_plane, bus_sector} = '0;
        {sector_locked, supply_ok} = 2'b01;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd("reset status", STATUS_RST, 8'hff);
        // Program: busy, plane bit, success
        wr(CMD_PROG, 5'd3);
        wr(8'h5a, 5'd3);
        @(posedge sys_clk);
        #1 chk("busy bit", 16'h0, {15'h0, dsw[7]});
        chk("own plane", 16'h0, {15'h0, dsw[0]});
        @(posedge sys_clk) bus_plane <= 5'd5;
        #1 chk("other plane", 16'h1, {15'h0, dsw[0]});
        wait_ready();
        rd("program ok", 8'h80, 8'hfe);
        // Program failure, sticky until clear
        fail_next <= 1'b1;
        wr(CMD_PROG, 5'd3);
        wr(8'h5a, 5'd3);
        wait_ready();
        rd("program fail", 8'h90, 8'hfe);
        wr(CMD_RDSTAT, 5'd3);
        #1 chk("status mode", 16'h1, {15'h0, status_mode});
        rd("held error", 8'h90, 8'hfe);
        wr(CMD_CLRSTAT, 5'd3);
        rd("cleared", 8'h80, 8'hfe);
        // Erase failure
        wr(CMD_ERASE, 5'd1);
        wr(CMD_RESUME, 5'd1);
        wait_ready();
        rd("erase fail", 8'ha0, 8'hfe);
        fail_next <= 1'b0;
        wr(CMD_CLRSTAT, 5'd1);
        // Every erase kind, successful
        for (int i = 0; i < 3; i++) begin
            wr(i == 0 ? CMD_ERASE : i == 1 ? CMD_PERASE : CMD_CERASE, 5'd1);
            wr(CMD_RESUME, 5'd1);
            @(posedge sys_clk);
            #1 chk("erase kind", 16'(i + 1), {14'h0, start_kind});
            if (i == 2) wr(CMD_SUSPEND, 5'd1);
            if (i == 2) #1 chk("chip no hold", 16'h0, {15'h0, core_hold});
            wait_ready();
            rd("erase ok", 8'h80, 8'hfe);
        end
        // Locked sector
        @(posedge sys_clk) sector_locked <= 1'b1;
        wr(CMD_ERASE, 5'd1);
        wr(CMD_RESUME, 5'd1);
        rd("lock abort", 8'h82, 8'hfe);
        sector_locked <= 1'b0;
        wr(CMD_CLRSTAT, 5'd1);
        // Sequence error
        wr(CMD_ERASE, 5'd1);
        wr(CMD_READ, 5'd1);
        rd("sequence error", 8'hba, 8'hfe);
        wr(CMD_CLRSTAT, 5'd1);
        // Low supply aborts a program
        wr(CMD_PROG, 5'd3);
        wr(8'h5a, 5'd3);
        @(posedge sys_clk) supply_ok <= 1'b0;
        wait_ready();
        rd("supply low", 8'h88, 8'hfe);
        @(posedge sys_clk) supply_ok <= 1'b1;
        wr(CMD_CLRSTAT, 5'd3);
        rd("supply cleared", 8'h80, 8'hfe);
        // Erase suspend at a foreign address
        wr(CMD_ERASE, 5'd2);
        wr(CMD_RESUME, 5'd2);
        wr(CMD_SUSPEND, 5'd9);
        wait_ready();
        chk("suspend time", 16'h1, {15'h0, n <= SUSP_MAX_CYC});
        rd("suspended", 8'hc0, 8'hfe);
        s0 = starts;
        for (int i = 0; i < 3; i++) begin
            wr(i == 0 ? CMD_ERASE : i == 1 ? CMD_PERASE : CMD_CERASE, 5'd7);
            wr(CMD_RESUME, 5'd7);
        end
        chk("refused starts", 16'(s0), 16'(starts));
        rd("still suspended", 8'hc0, 8'hfe);
        wr(CMD_RESUME, 5'd2);
        @(posedge sys_clk);
        #1 chk("resume start", 16'(s0 + 1), 16'(starts));
        wait_ready();
        rd("resumed done", 8'h80, 8'hfe);
        // Program beside a suspended erase
        wr(CMD_ERASE, 5'd2);
        wr(CMD_RESUME, 5'd2);
        wr(CMD_SUSPEND, 5'd2);
        wait_ready();
        @(posedge sys_clk) bus_sector <= 9'd5;
        wr(CMD_PROG, 5'd4);
        wr(8'h5a, 5'd4);
        @(posedge sys_clk);
        #1 chk("program in suspend", 16'h0, {14'h0, start_kind});
        wait_ready();
        rd("prog beside done", 8'hc0, 8'hfe);
        end_sim();
    end
endmodule
